/* File: bench/fdcr_disk_model.sv */
`default_nettype none
module fdcr_disk_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic take_en,
  input wire logic send,
  input wire logic [7:0] send_byte,
  output logic [23:0] got_hist,
  output logic [7:0] n_got
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h5A;
      got_hist <= 24'h0;
      n_got <= 8'h0;
    end else begin
      tx_ready <= take_en;
      rx_valid <= send;
      // Idle data toggles so a stale byte never passes
      rx_data <= send ? send_byte : ~rx_data;
      if (tx_valid && tx_ready) begin
        got_hist <= {got_hist[15:0], tx_data};
        n_got <= n_got + 8'h1;
      end
    end
  end
endmodule : fdcr_disk_model
`default_nettype wire

/* File: bench/fdcr_top_sva.sv */
`default_nettype none
module fdcr_top_sva (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_WDATA,
  input wire logic [7:0] IO_RDATA,
  input wire logic DIGITAL_OUTPUT_RESET_N,
  input wire logic [1:0] DRIVE_TYPE_MAP,
  input wire logic [1:0] DRIVE_SEEKING,
  input wire logic CMD_BUSY,
  input wire logic EXEC_PHASE,
  input wire logic POLLED_MODE,
  input wire logic HOST_READS,
  input wire logic CORE_TX_VALID,
  input wire logic CORE_TX_READY,
  input wire logic [7:0] CORE_TX_DATA,
  input wire logic CTRL_RESET,
  input wire logic LOW_POWER,
  input wire logic [7:0] SHADOW_RATE_CTRL,
  input wire logic [1:0] RATE_CODE,
  input wire logic DENSITY_SELECT,
  input wire logic DRIVE_DENSITY_OUT_A,
  input wire logic DRIVE_DENSITY_OUT_B,
  input wire logic [2:0] WRITE_COMP_STEPS
);
  wire st_rd = IO_RD && IO_ADDR == 10'h3F4;
  wire ctl_wr = IO_WR && IO_ADDR == 10'h3F4;
  logic [1:0] den_exp;
  // Expected {out_b, out_a} per drive type map
  always_comb begin
    case (DRIVE_TYPE_MAP)
      2'h0: den_exp = {RATE_CODE[0], DENSITY_SELECT};
      2'h1: den_exp = {RATE_CODE[0], !DENSITY_SELECT};
      2'h2: den_exp = {RATE_CODE[0], RATE_CODE[1]};
      default: den_exp = RATE_CODE;
    endcase
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  a_status_low: assert property (
    st_rd |=> IO_RDATA[5:0] == $past({POLLED_MODE && EXEC_PHASE, CMD_BUSY, 2'h0, DRIVE_SEEKING}))
    else $error("status low bits wrong");
  a_status_dir: assert property (st_rd |=> IO_RDATA[6] == $past(HOST_READS))
    else $error("status direction wrong");
  a_no_permit: assert property (st_rd && CTRL_RESET |=> !IO_RDATA[7])
    else $error("permit shown during reset");
  a_shadow_copy: assert property (ctl_wr |-> ##2 SHADOW_RATE_CTRL == $past(IO_WDATA, 2))
    else $error("shadow not updated");
  a_rate_code: assert property (ctl_wr |-> ##2 RATE_CODE == $past(IO_WDATA[1:0], 2))
    else $error("rate code wrong");
  a_soft_pulse: assert property (
    ctl_wr && IO_WDATA[7] && DIGITAL_OUTPUT_RESET_N |-> ##2 CTRL_RESET ##1 !CTRL_RESET)
    else $error("soft reset pulse wrong");
  a_held_reset: assert property (!DIGITAL_OUTPUT_RESET_N |=> CTRL_RESET)
    else $error("held reset not shown");
  a_low_power_on: assert property (
    ctl_wr && IO_WDATA[6] && !IO_WDATA[7] && DIGITAL_OUTPUT_RESET_N && !CTRL_RESET |=> LOW_POWER)
    else $error("low power not entered");
  a_low_power_off: assert property (st_rd |=> !LOW_POWER)
    else $error("low power kept after status read");
  a_density_sel: assert property (
    $stable(RATE_CODE) |-> DENSITY_SELECT == (RATE_CODE[1] == RATE_CODE[0]))
    else $error("density select wrong");
  a_density_map: assert property (
    $past(RST_N) && $stable(RATE_CODE) && $stable(DRIVE_TYPE_MAP)
    |-> {DRIVE_DENSITY_OUT_B, DRIVE_DENSITY_OUT_A} == den_exp)
    else $error("density outputs wrong");
  a_comp_steps: assert property (
    ctl_wr && IO_WDATA[4:2] != 3'h0 |-> ##2
    WRITE_COMP_STEPS == ($past(IO_WDATA[4:2], 2) == 3'h7 ? 3'h0 : $past(IO_WDATA[4:2], 2)))
    else $error("write_comp_code steps wrong");
  a_tx_hold: assert property (CORE_TX_VALID && !CORE_TX_READY && !CTRL_RESET && DIGITAL_OUTPUT_RESET_N
    && !$past(ctl_wr && IO_WDATA[7]) |=> CORE_TX_VALID && $stable(CORE_TX_DATA))
    else $error("stalled byte dropped");
  c_soft: cover property (ctl_wr && IO_WDATA[7]);
  c_stall: cover property (CORE_TX_VALID && !CORE_TX_READY);
  c_lp: cover property (LOW_POWER ##1 !LOW_POWER);
endmodule : fdcr_top_sva
bind fdcr_top fdcr_top_sva fdcr_top_sva_i (.CORE_CLK, .RST_N, .IO_ADDR, .IO_RD, .IO_WR, .IO_WDATA,
  .IO_RDATA, .DIGITAL_OUTPUT_RESET_N, .DRIVE_TYPE_MAP, .DRIVE_SEEKING, .CMD_BUSY, .EXEC_PHASE, .POLLED_MODE,
  .HOST_READS, .CORE_TX_VALID, .CORE_TX_READY, .CORE_TX_DATA, .CTRL_RESET, .LOW_POWER,
  .SHADOW_RATE_CTRL, .RATE_CODE, .DENSITY_SELECT, .DRIVE_DENSITY_OUT_A, .DRIVE_DENSITY_OUT_B,
  .WRITE_COMP_STEPS);
`default_nettype wire

/* File: bench/fdcr_top_tb.sv */
`default_nettype none
module fdcr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] ST = 10'h3F4;
  localparam logic [9:0] DT = 10'h3F5;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, IO_RD = 1'b0, IO_WR = 1'b0, DIGITAL_OUTPUT_RESET_N = 1'b1;
  logic CMD_BUSY = 1'b0, EXEC_PHASE = 1'b0, POLLED_MODE = 1'b0, HOST_READS = 1'b0, FIFO_ENABLE = 1'b0;
  logic [9:0] IO_ADDR = 10'h0;
  logic [7:0] IO_WDATA = 8'h0, COMP_START_TRACK = 8'h0, CUR_TRACK = 8'h0, send_byte = 8'h0;
  logic [1:0] DRIVE_RATE_TYPE = 2'h0, DRIVE_TYPE_MAP = 2'h0, DRIVE_SEEKING = 2'h0;
  logic [3:0] FIFO_THRESHOLD = 4'h1;
  logic take_en = 1'b0, send = 1'b0, seen;
  logic CORE_RX_VALID, CORE_TX_READY, CORE_TX_VALID, CTRL_RESET, LOW_POWER, DENSITY_SELECT;
  logic DRIVE_DENSITY_OUT_A, DRIVE_DENSITY_OUT_B, WRITE_COMP_HALF, WRITE_COMP_ON, XFER_ERROR, DMA_REQ;
  logic [7:0] CORE_RX_DATA, IO_RDATA, CORE_TX_DATA, SHADOW_RATE_CTRL, n_got, n0, s;
  logic [2:0] WRITE_COMP_STEPS, r;
  logic [1:0] RATE_CODE;
  logic [23:0] got_hist;
  fdcr_pkg::fdcr_rate_type DATA_RATE;
  int n_errors = 0, checks = 0;
  always #12.5 CORE_CLK = ~CORE_CLK;
  fdcr_top fdcr_top_i (.CORE_CLK, .RST_N, .IO_ADDR, .IO_RD, .IO_WR, .IO_WDATA, .IO_RDATA, .DIGITAL_OUTPUT_RESET_N,
    .DRIVE_RATE_TYPE, .DRIVE_TYPE_MAP, .DRIVE_SEEKING, .CMD_BUSY, .EXEC_PHASE, .POLLED_MODE, .HOST_READS,
    .FIFO_ENABLE, .FIFO_THRESHOLD, .COMP_START_TRACK, .CUR_TRACK, .CORE_RX_VALID, .CORE_RX_DATA,
    .CORE_TX_VALID, .CORE_TX_READY, .CORE_TX_DATA, .CTRL_RESET, .LOW_POWER, .SHADOW_RATE_CTRL, .RATE_CODE,
    .DATA_RATE, .DENSITY_SELECT, .DRIVE_DENSITY_OUT_A, .DRIVE_DENSITY_OUT_B, .WRITE_COMP_STEPS,
    .WRITE_COMP_HALF, .WRITE_COMP_ON, .XFER_ERROR, .DMA_REQ);
  fdcr_disk_model fdcr_disk_model_i (.clk(CORE_CLK), .rst_n(RST_N), .tx_valid(CORE_TX_VALID),
    .tx_data(CORE_TX_DATA), .tx_ready(CORE_TX_READY), .rx_valid(CORE_RX_VALID), .rx_data(CORE_RX_DATA),
    .take_en, .send, .send_byte, .got_hist, .n_got);
  task finish_test;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tk(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : tk
  // Callers keep bit 5 of control writes zero
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    IO_ADDR <= a;
    IO_WDATA <= d;
    IO_WR <= 1'b1;
    @(posedge CORE_CLK);
    IO_WR <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge CORE_CLK);
    IO_ADDR <= a;
    IO_RD <= 1'b1;
    @(posedge CORE_CLK);
    IO_RD <= 1'b0;
    tk(1);
    d = IO_RDATA;
  endtask : rd
  task wait_permit;
    s = 8'h0;
    for (int i = 0; i < 30 && s[7] !== 1'b1; i++) rd(ST, s);
    if (s[7] !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: permit wait ran out, status %h", $time, s);
      finish_test();
    end
  endtask : wait_permit
  task t_reset;
    chk(SHADOW_RATE_CTRL, 8'h02);
    chk(RATE_CODE, 2'h2);
    chk(DATA_RATE, 3'h0);
    chk(WRITE_COMP_STEPS, 3'h3);
    chk(WRITE_COMP_ON, 1'b1);
    @(posedge CORE_CLK);
    COMP_START_TRACK <= 8'h05;
    CUR_TRACK <= 8'h04;
    tk(2);
    chk(WRITE_COMP_ON, 1'b0);
    @(posedge CORE_CLK);
    CUR_TRACK <= 8'h05;
    tk(2);
    chk(WRITE_COMP_ON, 1'b1);
  endtask : t_reset
  task t_rates;
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 4; c++) begin
        @(posedge CORE_CLK);
        DRIVE_RATE_TYPE <= 2'(t);
        DRIVE_TYPE_MAP <= 2'(c);
        wr(ST, 8'(c));
        tk(2);
        r = c == 3 ? 3'h3 : c == 0 ? 3'h2 : c == 2 ? 3'h0 : t == 1 ? 3'h2 : t == 2 ? 3'h4 : 3'h1;
        chk(DATA_RATE, r);
        chk(WRITE_COMP_STEPS, r > 3'h2 ? 3'h1 : 3'h3);
        chk({RATE_CODE, DENSITY_SELECT, DRIVE_DENSITY_OUT_B, DRIVE_DENSITY_OUT_A, WRITE_COMP_HALF},
            {2'(c), (c == 0 ? 3'h5 : c == 1 ? 3'h3 : c == 2 ? 3'h1 : 3'h7), r == 3'h4});
      end
    end
    for (int c = 0; c < 8; c++) begin
      wr(ST, 8'((c << 2) | 1));
      tk(2);
      chk(WRITE_COMP_STEPS, c == 7 ? 3'h0 : c == 0 ? 3'h1 : 3'(c));
      chk(WRITE_COMP_HALF, 1'b1);
    end
  endtask : t_rates
  task t_soft;
    wr(ST, 8'h41);
    tk(1);
    chk(LOW_POWER, 1'b1);
    @(posedge CORE_CLK);
    DIGITAL_OUTPUT_RESET_N <= 1'b0;
    tk(2);
    chk({CTRL_RESET, LOW_POWER}, 2'h2);
    rd(ST, s);
    chk(s[7], 1'b0);
    @(posedge CORE_CLK);
    DIGITAL_OUTPUT_RESET_N <= 1'b1;
    tk(3);
    chk({CTRL_RESET, RATE_CODE, SHADOW_RATE_CTRL}, 11'h141);
    wr(ST, 8'h40);
    rd(ST, s);
    chk(LOW_POWER, 1'b0);
    wr(ST, 8'h83);
    tk(1);
    chk(CTRL_RESET, 1'b1);
    tk(1);
    chk({CTRL_RESET, RATE_CODE, SHADOW_RATE_CTRL}, 11'h383);
    // Hard reset in mid-run brings the rate register back
    @(posedge CORE_CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    tk(2);
    chk({CTRL_RESET, RATE_CODE, SHADOW_RATE_CTRL}, 11'h202);
  endtask : t_soft
  task t_status;
    @(posedge CORE_CLK);
    DRIVE_SEEKING <= 2'h2;
    CMD_BUSY <= 1'b1;
    POLLED_MODE <= 1'b1;
    rd(ST, s);
    chk(s, 8'h92);
    @(posedge CORE_CLK);
    DRIVE_SEEKING <= 2'h1;
    CMD_BUSY <= 1'b0;
    EXEC_PHASE <= 1'b1;
    HOST_READS <= 1'b1;
    rd(ST, s);
    chk(s, 8'h61);
    @(posedge CORE_CLK);
    EXEC_PHASE <= 1'b0;
    HOST_READS <= 1'b0;
  endtask : t_status
  task t_buffer;
    n0 = n_got;
    for (int i = 0; i < 3; i++) begin
      wait_permit();
      wr(DT, 8'hA5 ^ 8'(i * 8'h33));
    end
    rd(ST, s);
    chk(s[7], 1'b0);
    wr(DT, 8'hEE);
    @(posedge CORE_CLK);
    take_en <= 1'b1;
    for (int i = 0; i < 20 && n_got != n0 + 8'h3; i++) tk(1);
    tk(4);
    chk({n_got - n0, got_hist}, 32'h03A596C3);
    @(posedge CORE_CLK);
    take_en <= 1'b0;
  endtask : t_buffer
  task t_read;
    @(posedge CORE_CLK);
    HOST_READS <= 1'b1;
    send <= 1'b1;
    send_byte <= 8'h69;
    @(posedge CORE_CLK);
    send <= 1'b0;
    wait_permit();
    rd(DT, s);
    chk(s, 8'h69);
    rd(DT, s);
    chk(s, 8'h69);
    rd(ST, s);
    chk(s[7], 1'b0);
  endtask : t_read
  task t_errors;
    @(posedge CORE_CLK);
    EXEC_PHASE <= 1'b1;
    tk(2);
    @(posedge CORE_CLK);
    send <= 1'b1;
    send_byte <= 8'h11;
    @(posedge CORE_CLK);
    send_byte <= 8'h22;
    @(posedge CORE_CLK);
    send <= 1'b0;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      tk(1);
      seen |= XFER_ERROR;
    end
    chk(seen, 1'b1);
    rd(DT, s);
    chk(s, 8'h11);
    @(posedge CORE_CLK);
    FIFO_ENABLE <= 1'b1;
    FIFO_THRESHOLD <= 4'h2;
    send <= 1'b1;
    send_byte <= 8'h33;
    repeat (2) @(posedge CORE_CLK);
    send <= 1'b0;
    tk(4);
    chk(DMA_REQ, 1'b1);
    @(posedge CORE_CLK);
    EXEC_PHASE <= 1'b0;
    HOST_READS <= 1'b0;
    FIFO_ENABLE <= 1'b0;
    @(posedge CORE_CLK);
    EXEC_PHASE <= 1'b1;
    take_en <= 1'b1;
    seen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      tk(1);
      seen |= XFER_ERROR;
    end
    chk({seen, got_hist[7:0]}, 9'h100);
    @(posedge CORE_CLK);
    EXEC_PHASE <= 1'b0;
    take_en <= 1'b0;
  endtask : t_errors
  initial begin
    repeat (12) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    tk(2);
    t_reset();
    t_rates();
    t_soft();
    t_status();
    t_buffer();
    t_read();
    t_errors();
    finish_test();
  end
endmodule : fdcr_top_tb
`default_nettype wire

/* File: hw/fdcr_defines.svh */
`ifndef FDCR_DEFINES_SVH
`define FDCR_DEFINES_SVH

// Host port addresses
`define FDCR_ADDR_STATUS 10'h3F4
`define FDCR_ADDR_DATA 10'h3F5

// Rate control register layout and reset value
`define FDCR_RATE_CTRL_RESET 8'h02
`define FDCR_RATE_LSB 0
`define FDCR_RATE_MSB 1
`define FDCR_COMP_LSB 2
`define FDCR_COMP_MSB 4
`define FDCR_LOW_POWER_BIT 6
`define FDCR_SOFT_RESET_BIT 7

// Precompensation codes and step counts (one step is 41.67 ns, half at 2 Mbps)
`define FDCR_COMP_DEFAULT 3'h0
`define FDCR_COMP_NONE 3'h7
`define FDCR_COMP_STEP_PS 41670
`define FDCR_COMP_DEF_STEPS_FAST 3'h1
`define FDCR_COMP_DEF_STEPS_SLOW 3'h3

// Rate select codes
`define FDCR_CODE_500K 2'h0
`define FDCR_CODE_300K 2'h1
`define FDCR_CODE_250K 2'h2
`define FDCR_CODE_1M 2'h3

// Drive rate types and drive type map
`define FDCR_DRT_THREE_MODE 2'h1
`define FDCR_DRT_TWO_MEG 2'h2
`define FDCR_DT_STD 2'h0
`define FDCR_DT_INV 2'h1
`define FDCR_DT_RATE 2'h2

// Data FIFO
`define FDCR_FIFO_DEPTH 16
`define FDCR_PAD_BYTE 8'h00

`endif

/* File: hw/fdcr_fifo.sv */
`default_nettype none
module fdcr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fdcr_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  logic do_push;
  logic do_pop;

  assign in_ready = (cnt_ff != CW'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem[rd_ptr_ff];
  assign count = cnt_ff;
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else if (flush) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (do_pop) rd_ptr_ff <= rd_ptr_ff + AW'(1);
      cnt_ff <= cnt_ff + CW'(do_push) - CW'(do_pop);
    end
  end
endmodule : fdcr_fifo
`default_nettype wire

/* File: hw/fdcr_pkg.sv */
`default_nettype none
package fdcr_pkg;
  typedef enum logic [2:0] {RATE_250K, RATE_300K, RATE_500K, RATE_1M, RATE_2M} fdcr_rate_type;

  typedef struct packed {
    logic [7:0] rate_ctrl;
    logic [7:0] shadow;
    logic low_power;
    logic ctrl_reset;
    logic exec_q;
    logic pad;
    logic xfer_err;
    logic dma_req;
    logic [7:0] rdata;
    logic [1:0] rate_code;
    fdcr_rate_type data_rate;
    logic density;
    logic den_a;
    logic den_b;
    logic [2:0] comp_steps;
    logic comp_half;
    logic comp_on;
  } fdcr_state_type;
endpackage : fdcr_pkg
`default_nettype wire

/* File: hw/fdcr_skid.sv */
`default_nettype none
module fdcr_skid #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  initial begin
    if (WIDTH < 1) $error("fdcr_skid: WIDTH must be positive");
  end

  // Main stage drives the outputs, spare stage catches a word during a stall
  logic [WIDTH-1:0] main_ff;
  logic [WIDTH-1:0] spare_ff;
  logic main_v_ff;
  logic spare_v_ff;

  assign in_ready = !spare_v_ff;
  assign out_valid = main_v_ff;
  assign out_data = main_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_ff <= '0;
      spare_ff <= '0;
      main_v_ff <= 1'b0;
      spare_v_ff <= 1'b0;
    end else if (flush) begin
      main_v_ff <= 1'b0;
      spare_v_ff <= 1'b0;
    end else begin
      if (!main_v_ff || out_ready) begin
        if (spare_v_ff) begin
          main_ff <= spare_ff;
          main_v_ff <= 1'b1;
          spare_v_ff <= 1'b0;
        end else begin
          main_ff <= in_data;
          main_v_ff <= in_valid;
        end
      end else if (in_valid && !spare_v_ff) begin
        spare_ff <= in_data;
        spare_v_ff <= 1'b1;
      end
    end
  end
endmodule : fdcr_skid
`default_nettype wire

/* File: hw/fdcr_top.sv */
`include "fdcr_defines.svh"
`default_nettype none
// What this block does
// - Rate bits survive soft reset, hard reset 250K
// - Bits 2-4 choose write precompensation delay
// - Precompensation starts at configured track, default zero
// - Bit 6 enters low power; status reads and data accesses leave it
// - Bit 7 soft resets, then clears itself
// - Every control write copied to readable shadow
// - Type 00 rate, density and rate outputs
// - Types 01 and 10 remap code 01
// - Drive type map selects density outputs
// - Default precompensation delay depends on rate
// - Status valid right after data transfer
// - Status bits 0-1 show drive seeking
// - Status bit 4 shows command busy
// - Status bit 5 marks polled execution
// - Status bit 6 gives transfer direction
// - Bit 7 permits data access, else refused
// - FIFO disabled after reset, configure enables
// - Parameters unbuffered; FIFO cleared entering execution
// - Overrun/underrun flag transfer error; underrun writes pad zeros
// - Hard reset loads 02, soft keeps it
// - Digital-output reset spares rate register
module fdcr_top #(
  parameter int FIFO_DEPTH = `FDCR_FIFO_DEPTH
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [9:0] IO_ADDR,
  input wire logic IO_RD,
  input wire logic IO_WR,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  input wire logic DIGITAL_OUTPUT_RESET_N,
  input wire logic [1:0] DRIVE_RATE_TYPE,
  input wire logic [1:0] DRIVE_TYPE_MAP,
  input wire logic [1:0] DRIVE_SEEKING,
  input wire logic CMD_BUSY,
  input wire logic EXEC_PHASE,
  input wire logic POLLED_MODE,
  input wire logic HOST_READS,
  input wire logic FIFO_ENABLE,
  input wire logic [3:0] FIFO_THRESHOLD,
  input wire logic [7:0] COMP_START_TRACK,
  input wire logic [7:0] CUR_TRACK,
  input wire logic CORE_RX_VALID,
  input wire logic [7:0] CORE_RX_DATA,
  output logic CORE_TX_VALID,
  input wire logic CORE_TX_READY,
  output logic [7:0] CORE_TX_DATA,
  output logic CTRL_RESET,
  output logic LOW_POWER,
  output logic [7:0] SHADOW_RATE_CTRL,
  output logic [1:0] RATE_CODE,
  output fdcr_pkg::fdcr_rate_type DATA_RATE,
  output logic DENSITY_SELECT,
  output logic DRIVE_DENSITY_OUT_A,
  output logic DRIVE_DENSITY_OUT_B,
  output logic [2:0] WRITE_COMP_STEPS,
  output logic WRITE_COMP_HALF,
  output logic WRITE_COMP_ON,
  output logic XFER_ERROR,
  output logic DMA_REQ
);
  localparam int CW = $clog2(FIFO_DEPTH+1);

  initial begin
    if (FIFO_DEPTH < 16 || FIFO_DEPTH > 256) $error("fdcr_top: FIFO_DEPTH must be 16 to 256");
  end

  fdcr_pkg::fdcr_state_type st_ff;
  fdcr_pkg::fdcr_state_type nxt_st;

  logic wr_ctl;
  logic rd_status;
  logic data_acc;
  logic soft_reset;
  logic entering_exec;
  logic fifo_mode;
  logic [CW-1:0] limit;
  logic room;
  logic permit;
  logic [7:0] status;
  logic host_push;
  logic host_pop;
  logic fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_out_ready;
  logic [CW-1:0] fifo_count;
  logic skid_in_valid;
  logic skid_in_ready;
  logic [7:0] skid_in_data;
  logic overrun;
  logic underrun;
  logic [1:0] code;
  logic [2:0] comp;
  logic [CW-1:0] thr;

  // Address is shared: direction picks status or control
  assign wr_ctl = IO_WR && (IO_ADDR == `FDCR_ADDR_STATUS);
  assign rd_status = IO_RD && (IO_ADDR == `FDCR_ADDR_STATUS);
  assign data_acc = (IO_RD || IO_WR) && (IO_ADDR == `FDCR_ADDR_DATA);
  assign soft_reset = !DIGITAL_OUTPUT_RESET_N || st_ff.rate_ctrl[`FDCR_SOFT_RESET_BIT];
  assign entering_exec = EXEC_PHASE && !st_ff.exec_q;

  // Full depth only in execution with FIFO configured; otherwise one byte
  assign fifo_mode = FIFO_ENABLE && EXEC_PHASE;
  assign limit = fifo_mode ? CW'(FIFO_DEPTH) : CW'(1);
  assign room = fifo_count < limit;
  assign thr = (fifo_mode && (FIFO_THRESHOLD != 4'h0)) ? CW'(FIFO_THRESHOLD) : CW'(1);

  // Permit is computed from live state so a read right after a transfer is current
  assign permit = !st_ff.ctrl_reset && (HOST_READS ? fifo_out_valid : (room && !st_ff.pad));
  assign status = {permit, HOST_READS, POLLED_MODE && EXEC_PHASE, CMD_BUSY,
                   2'h0, DRIVE_SEEKING};

  // Accesses while permit is low are dropped
  assign host_push = IO_WR && data_acc && permit && !HOST_READS;
  assign host_pop = IO_RD && data_acc && permit && HOST_READS;

  assign fifo_in_valid = HOST_READS ? (CORE_RX_VALID && room) : host_push;
  assign fifo_in_data = HOST_READS ? CORE_RX_DATA : IO_WDATA;
  assign fifo_out_ready = HOST_READS ? host_pop : skid_in_ready;
  assign skid_in_valid = st_ff.pad || (!HOST_READS && fifo_out_valid);
  assign skid_in_data = st_ff.pad ? `FDCR_PAD_BYTE : fifo_out_data;

  assign overrun = EXEC_PHASE && HOST_READS && CORE_RX_VALID && !room;
  assign underrun = EXEC_PHASE && !HOST_READS && CORE_TX_READY && !CORE_TX_VALID && !st_ff.pad;

  fdcr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_reset || entering_exec),
    .in_valid(fifo_in_valid),
    .in_ready(),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .count(fifo_count)
  );

  fdcr_skid #(
    .WIDTH(8)
  ) u_skid (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .flush(soft_reset),
    .in_valid(skid_in_valid),
    .in_ready(skid_in_ready),
    .in_data(skid_in_data),
    .out_valid(CORE_TX_VALID),
    .out_ready(CORE_TX_READY),
    .out_data(CORE_TX_DATA)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.exec_q = EXEC_PHASE;
    nxt_st.xfer_err = overrun || underrun;
    nxt_st.ctrl_reset = soft_reset;
    nxt_st.rdata = st_ff.rdata;

    // Control write: soft reset never touches this register
    if (wr_ctl) begin
      nxt_st.rate_ctrl = IO_WDATA;
      nxt_st.shadow = IO_WDATA;
    end else begin
      nxt_st.rate_ctrl[`FDCR_SOFT_RESET_BIT] = 1'b0;
    end

    // Leaving low power wins over entering it
    if (wr_ctl && IO_WDATA[`FDCR_LOW_POWER_BIT]) begin
      nxt_st.low_power = 1'b1;
    end
    if (soft_reset || rd_status || data_acc) begin
      nxt_st.low_power = 1'b0;
    end

    if (rd_status) begin
      nxt_st.rdata = status;
    end else if (host_pop) begin
      nxt_st.rdata = fifo_out_data;
    end

    // Pad mode feeds zeros to the core until the execution phase ends or a soft reset
    if (underrun) begin
      nxt_st.pad = 1'b1;
    end else if (!EXEC_PHASE || soft_reset) begin
      nxt_st.pad = 1'b0;
    end

    nxt_st.dma_req = fifo_mode && !st_ff.pad &&
                     (HOST_READS ? (fifo_count >= thr) : ((CW'(FIFO_DEPTH) - fifo_count) >= thr));

    // Rate decode
    code = st_ff.rate_ctrl[`FDCR_RATE_MSB:`FDCR_RATE_LSB];
    nxt_st.rate_code = code;
    nxt_st.density = (code == `FDCR_CODE_1M) || (code == `FDCR_CODE_500K);
    case (code)
      `FDCR_CODE_1M: nxt_st.data_rate = fdcr_pkg::RATE_1M;
      `FDCR_CODE_500K: nxt_st.data_rate = fdcr_pkg::RATE_500K;
      `FDCR_CODE_250K: nxt_st.data_rate = fdcr_pkg::RATE_250K;
      default: begin
        if (DRIVE_RATE_TYPE == `FDCR_DRT_THREE_MODE) begin
          nxt_st.data_rate = fdcr_pkg::RATE_500K;
        end else if (DRIVE_RATE_TYPE == `FDCR_DRT_TWO_MEG) begin
          nxt_st.data_rate = fdcr_pkg::RATE_2M;
        end else begin
          nxt_st.data_rate = fdcr_pkg::RATE_300K;
        end
      end
    endcase

    case (DRIVE_TYPE_MAP)
      `FDCR_DT_STD: begin
        nxt_st.den_b = code[0];
        nxt_st.den_a = nxt_st.density;
      end
      `FDCR_DT_RATE: begin
        nxt_st.den_b = code[0];
        nxt_st.den_a = code[1];
      end
      `FDCR_DT_INV: begin
        nxt_st.den_b = code[0];
        nxt_st.den_a = !nxt_st.density;
      end
      default: begin
        nxt_st.den_b = code[1];
        nxt_st.den_a = code[0];
      end
    endcase

    // Precompensation in 41.67 ns steps, halved at 2 Mbps
    comp = st_ff.rate_ctrl[`FDCR_COMP_MSB:`FDCR_COMP_LSB];
    nxt_st.comp_half = (nxt_st.data_rate == fdcr_pkg::RATE_2M);
    case (comp)
      `FDCR_COMP_NONE: nxt_st.comp_steps = 3'h0;
      `FDCR_COMP_DEFAULT: begin
        if (nxt_st.data_rate == fdcr_pkg::RATE_2M || nxt_st.data_rate == fdcr_pkg::RATE_1M) begin
          nxt_st.comp_steps = `FDCR_COMP_DEF_STEPS_FAST;
        end else begin
          nxt_st.comp_steps = `FDCR_COMP_DEF_STEPS_SLOW;
        end
      end
      default: nxt_st.comp_steps = comp;
    endcase
    nxt_st.comp_on = (CUR_TRACK >= COMP_START_TRACK) && (nxt_st.comp_steps != 3'h0);
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_ff <= '{rate_ctrl: `FDCR_RATE_CTRL_RESET, shadow: `FDCR_RATE_CTRL_RESET,
                 rate_code: `FDCR_CODE_250K, data_rate: fdcr_pkg::RATE_250K,
                 comp_steps: `FDCR_COMP_DEF_STEPS_SLOW, ctrl_reset: 1'b1,
                 default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign IO_RDATA = st_ff.rdata;
  assign CTRL_RESET = st_ff.ctrl_reset;
  assign LOW_POWER = st_ff.low_power;
  assign SHADOW_RATE_CTRL = st_ff.shadow;
  assign RATE_CODE = st_ff.rate_code;
  assign DATA_RATE = st_ff.data_rate;
  assign DENSITY_SELECT = st_ff.density;
  assign DRIVE_DENSITY_OUT_A = st_ff.den_a;
  assign DRIVE_DENSITY_OUT_B = st_ff.den_b;
  assign WRITE_COMP_STEPS = st_ff.comp_steps;
  assign WRITE_COMP_HALF = st_ff.comp_half;
  assign WRITE_COMP_ON = st_ff.comp_on;
  assign XFER_ERROR = st_ff.xfer_err;
  assign DMA_REQ = st_ff.dma_req;
endmodule : fdcr_top
`default_nettype wire
